// ---- pkg/ptp_stamp_pkg.sv ----
// shared constants, register map and carrier types of the frame timestamping block
package ptp_stamp_pkg;

	// register byte addresses, one aligned 32-bit word each
	localparam logic [4:0] ADDR_CTRL       = 5'h00;
	localparam logic [4:0] ADDR_ADJUST     = 5'h04;
	localparam logic [4:0] ADDR_TX_LATENCY = 5'h08;
	localparam logic [4:0] ADDR_RX_LATENCY = 5'h0C;
	localparam logic [4:0] ADDR_STATUS     = 5'h10;

	// control word field positions
	localparam int CTRL_TRANSP_BIT   = 0;
	localparam int CTRL_ONESTEP_BIT  = 1;
	localparam int CTRL_TX_LAT_BIT   = 2;
	localparam int CTRL_RX_LAT_BIT   = 3;
	localparam int CTRL_TX_GB_BIT    = 4;
	localparam int CTRL_RX_GB_BIT    = 5;
	localparam int CTRL_TX_RESET_BIT = 8;
	localparam int CTRL_WIDTH        = 6;

	// control reset value: both gearbox and rx static apply on, rest off
	localparam logic [5:0] CTRL_RESET = 6'h38;

	// status word field positions
	localparam int STAT_WR_FAULT_BIT = 0;
	localparam int STAT_RD_FAULT_BIT = 1;
	localparam int STAT_LEVEL_LSB    = 8;

	// adjust and latency field layout
	localparam int ADJ_WIDTH      = 11;
	localparam int ADJ_FRAC_BITS  = 3;
	localparam int LAT_FRAC_BITS  = 16;
	localparam int LAT_WIDTH      = 32;

	// timer layout
	localparam int TIMER_WIDTH = 80;
	localparam int TAG_WIDTH   = 16;
	localparam int NS_WIDTH    = 32;
	localparam int TC_SIGN_BIT = 63;
	localparam logic [32:0] NS_PER_SEC = 33'h0_3B9A_CA00;

	// per-frame operation codes
	typedef enum logic [1:0] {
		OP_NONE     = 2'h0,
		OP_ONE_STEP = 2'h1,
		OP_TWO_STEP = 2'h2,
		OP_RESERVED = 2'h3
	} stamp_op_t;

	// one pending transmit result
	typedef struct packed {
		logic                   check;
		logic [TAG_WIDTH-1:0]   tag;
		logic [TIMER_WIDTH-1:0] stamp;
	} tag_entry_t;

	// latched control word
	typedef struct packed {
		logic rx_gb_en;
		logic tx_gb_en;
		logic rx_lat_en;
		logic tx_lat_en;
		logic onestep_en;
		logic transparent;
	} ctrl_t;

endpackage

// ---- rtl/ptp_frame_timestamping.sv ----
// transmit and receive start-of-packet timestamping with tag queue and register slave
`timescale 1ns/10ps

// What this block does
// - transparent mode adds the transmit timer as a correction to the stamp
// - transparent mode forces correction sign bit 63 to zero, positive time
// - tag sampled on first packet cycle; ignored for no-operation codes
// - 1-step and 2-step frames return their tag unchanged with the stamp
// - 1-step stamp offset by 11-bit adjust: 10:3 ns, 2:0 fraction
// - tag queue write fault sets and holds until transmit path reset
// - tag queue read fault sets and holds until transmit path reset
// - every receive start of packet yields its capture timer value plus the enabled receive delays
// - transmit static latency is unsigned Q16.16, ns over fraction
// - receive static latency is Q16.16, ns over fraction
// - transmit static latency applied only when its control enables it
// - receive static latency applied when enabled, enabled after reset
// - transmit gearbox latency applied when enabled, enabled after reset
// - receive gearbox latency applied when enabled, enabled after reset
// - op code 00 none, 01 one-step, 10 two-step, 11 none
// - normal: ns low 32, seconds high 48; transparent: ns 62:16
// - valid strobe marks each returned transmit stamp and tag
module ptp_frame_timestamping
	import ptp_stamp_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// register slave
	input  wire logic [4:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	// transmit side
	input  wire logic [TIMER_WIDTH-1:0] tx_timer,
	input  wire logic                   tx_sop,
	input  wire logic [1:0]             tx_stamp_operation,
	input  wire logic [TAG_WIDTH-1:0]   tx_tag,
	input  wire logic [LAT_WIDTH-1:0]   tx_gearbox_latency,
	output logic                        tx_stamp_valid,
	output logic      [TAG_WIDTH-1:0]   tx_stamp_tag,
	output logic      [TIMER_WIDTH-1:0] tx_stamp,
	output logic                        tx_onestep_valid,
	output logic      [TIMER_WIDTH-1:0] tx_onestep_stamp,
	output logic                        tx_tag_write_fault,
	output logic                        tx_tag_read_fault,
	// receive side
	input  wire logic [TIMER_WIDTH-1:0] rx_timer,
	input  wire logic                   rx_sop,
	input  wire logic [LAT_WIDTH-1:0]   rx_gearbox_latency,
	output logic                        rx_stamp_valid,
	output logic      [TIMER_WIDTH-1:0] rx_stamp
);

	localparam int AW = $clog2(DEPTH);

	// pointer arithmetic needs a power-of-two depth of at least two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
		$error("DEPTH must be a power of two, at least 2");
	end

	// add a Q17.16 delay to a timer value in either time format
	function automatic logic [TIMER_WIDTH-1:0] stamp_add(
		input logic [TIMER_WIDTH-1:0] t,
		input logic [32:0]            d,
		input logic                   tc
	);
		logic [32:0] ns;
		logic [47:0] sec;
		ns  = {1'b0, t[NS_WIDTH-1:0]} + {16'h0000, d[32:LAT_FRAC_BITS]};
		sec = t[TIMER_WIDTH-1:NS_WIDTH];
		if (tc) begin
			// correction format keeps the fraction; bit 63 forced positive
			stamp_add = {t[79:64], 1'b0, 63'(t[62:0] + 63'(d))};
		end else begin
			// sub-ns part is dropped: ns field has no fraction
			// one wrap suffices: timer ns stays below one second, delays are small
			if (ns >= NS_PER_SEC) begin
				ns  = ns - NS_PER_SEC;
				sec = sec + 48'h0000_0000_0001;
			end
			stamp_add = {sec, ns[NS_WIDTH-1:0]};
		end
	endfunction

	// register slave state
	ctrl_t                  ctrl_q;
	logic [ADJ_WIDTH-1:0]   adjust_q;
	logic [LAT_WIDTH-1:0]   tx_lat_q;
	logic [LAT_WIDTH-1:0]   rx_lat_q;
	logic                   wait_q;
	logic [31:0]            rdata_q;
	logic                   tx_path_reset_q;
	logic                   bus_write;
	logic                   bus_accept;
	logic [31:0]            status_word;

	// tag queue, the read pointer addresses the head entry
	tag_entry_t             queue_mem [DEPTH];
	logic [AW:0]            wr_ptr_q;
	logic [AW:0]            rd_ptr_q;
	logic [AW:0]            level;
	logic                   queue_full;
	logic                   queue_empty;
	logic                   push;
	logic                   pop;
	tag_entry_t             head;

	// delay arithmetic, all in Q17.16
	logic [32:0]            tx_delay;
	logic [32:0]            rx_delay;
	logic [32:0]            onestep_delay;
	logic [TIMER_WIDTH-1:0] tx_two_step;
	stamp_op_t              op;

	// request takes effect on the edge where waitrequest is seen low
	assign bus_accept = (avs_read || avs_write) && !wait_q;
	assign bus_write  = avs_write && !wait_q;

	assign level       = wr_ptr_q - rd_ptr_q;
	assign queue_full  = level[AW];
	assign queue_empty = (level == '0);
	assign head        = queue_mem[rd_ptr_q[AW-1:0]];
	assign op          = stamp_op_t'(tx_stamp_operation);

	// only 1-step and 2-step frames take a stamp; other codes drop the tag
	assign push = tx_sop && (op == OP_ONE_STEP || op == OP_TWO_STEP);
	assign pop  = !queue_empty;

	// delay sums in Q17.16, each term gated by its apply control
	assign tx_delay = (ctrl_q.tx_lat_en ? {1'b0, tx_lat_q} : 33'h0)
		+ (ctrl_q.tx_gb_en ? {1'b0, tx_gearbox_latency} : 33'h0);
	assign rx_delay = (ctrl_q.rx_lat_en ? {1'b0, rx_lat_q} : 33'h0)
		+ (ctrl_q.rx_gb_en ? {1'b0, rx_gearbox_latency} : 33'h0);

	// adjust fraction has 3 bits, aligned up to the 16-bit latency fraction
	assign onestep_delay = tx_delay
		+ (33'(adjust_q) << (LAT_FRAC_BITS - ADJ_FRAC_BITS));

	assign tx_two_step = stamp_add(tx_timer, tx_delay, ctrl_q.transparent);

	// limitation: the level field only fits while the queue index stays below 24 bits
	assign status_word = {{(32 - STAT_LEVEL_LSB - AW - 1){1'b0}}, level,
		{(STAT_LEVEL_LSB - 2){1'b0}}, tx_tag_read_fault, tx_tag_write_fault};

	// bus handshake: one wait cycle, then a single accept cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b1;
		end else if ((avs_read || avs_write) && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	// read data is loaded during the wait cycle, stable at the accept edge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read && wait_q) begin
			unique case (avs_address)
				ADDR_CTRL:       rdata_q <= {26'h000_0000, ctrl_q};
				ADDR_ADJUST:     rdata_q <= {21'h00_0000, adjust_q};
				ADDR_TX_LATENCY: rdata_q <= tx_lat_q;
				ADDR_RX_LATENCY: rdata_q <= rx_lat_q;
				ADDR_STATUS:     rdata_q <= status_word;
				default:         rdata_q <= 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	// software-written control; unmapped writes are dropped
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_q   <= ctrl_t'(CTRL_RESET);
			adjust_q <= 11'h000;
			tx_lat_q <= 32'h0000_0000;
			rx_lat_q <= 32'h0000_0000;
		end else if (bus_write) begin
			unique case (avs_address)
				ADDR_CTRL:       ctrl_q   <= ctrl_t'(avs_writedata[CTRL_WIDTH-1:0]);
				ADDR_ADJUST:     adjust_q <= avs_writedata[ADJ_WIDTH-1:0];
				ADDR_TX_LATENCY: tx_lat_q <= avs_writedata;
				ADDR_RX_LATENCY: rx_lat_q <= avs_writedata;
				default:         ;
			endcase
		end
	end

	// transmit path reset pulse, self-clearing after one cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_path_reset_q <= 1'b0;
		end else begin
			tx_path_reset_q <= bus_write && (avs_address == ADDR_CTRL)
				&& avs_writedata[CTRL_TX_RESET_BIT];
		end
	end

	// tag queue storage; no reset needed, pointers guard the contents
	always_ff @(posedge clk_sys) begin
		if (push && !queue_full) begin
			queue_mem[wr_ptr_q[AW-1:0]] <= '{check: ^tx_tag, tag: tx_tag,
				stamp: tx_two_step};
		end
	end

	// queue pointers; a push into a full queue is lost and flagged
	// a path reset wins over a same-cycle push, so that frame is dropped
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else if (tx_path_reset_q) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push && !queue_full) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	// returned stamp, tag and strobe, one entry per cycle in queue order
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_stamp_valid <= 1'b0;
			tx_stamp_tag   <= 16'h0000;
			tx_stamp       <= 80'h0;
		end else begin
			tx_stamp_valid <= pop && !tx_path_reset_q;
			// a flushed entry must not move the tag while the strobe stays low
			if (pop && !tx_path_reset_q) begin
				tx_stamp_tag <= head.tag;
				tx_stamp     <= head.stamp;
			end
		end
	end

	// 1-step stamp for the inserter, offset from the 2-step value
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_onestep_valid <= 1'b0;
			tx_onestep_stamp <= 80'h0;
		end else begin
			tx_onestep_valid <= tx_sop && (op == OP_ONE_STEP) && ctrl_q.onestep_en;
			if (tx_sop && op == OP_ONE_STEP) begin
				tx_onestep_stamp <= stamp_add(tx_timer, onestep_delay,
					ctrl_q.transparent);
			end
		end
	end

	// write fault: set beats clear, only a transmit path reset clears it
	// a push lost in the reset cycle itself still leaves the flag set
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_tag_write_fault <= 1'b0;
		end else if (push && queue_full) begin
			tx_tag_write_fault <= 1'b1;
		end else if (tx_path_reset_q) begin
			tx_tag_write_fault <= 1'b0;
		end
	end

	// read fault: a stored entry whose check bit no longer matches its tag
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_tag_read_fault <= 1'b0;
		end else if (pop && (head.check != ^head.tag)) begin
			tx_tag_read_fault <= 1'b1;
		end else if (tx_path_reset_q) begin
			tx_tag_read_fault <= 1'b0;
		end
	end

	// every receive start of packet is stamped; the caller filters for PTP
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_stamp_valid <= 1'b0;
			rx_stamp       <= 80'h0;
		end else begin
			rx_stamp_valid <= rx_sop;
			if (rx_sop) begin
				rx_stamp <= stamp_add(rx_timer, rx_delay, ctrl_q.transparent);
			end
		end
	end

	// bus outputs come straight from their registers
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;

endmodule

// ---- testbench/ptp_stamp_checker.sv ----
// port assertions for the frame timestamping block
`timescale 1ns/10ps
module ptp_stamp_checker
	import ptp_stamp_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        tx_sop,
	input wire logic [1:0]  tx_stamp_operation,
	input wire logic        tx_stamp_valid,
	input wire logic [15:0] tx_stamp_tag,
	input wire logic        tx_onestep_valid,
	input wire logic        tx_tag_write_fault,
	input wire logic        tx_tag_read_fault,
	input wire logic        rx_sop,
	input wire logic        rx_stamp_valid
);
	localparam int MAXW = 20;
	// accepted transmit path reset; faults may only drop after one
	wire tx_clr = avs_write && !avs_waitrequest && avs_address == ADDR_CTRL
		&& avs_writedata[CTRL_TX_RESET_BIT];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// a waiting request gets exactly one wait cycle
	sequence bus_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence bus_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	bus_answer_a: assert property (bus_req |=> bus_ack)
		else $error("bus request not answered after one wait cycle");
	wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest dropped without a request");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest
		&& avs_address > ADDR_STATUS |-> avs_readdata == 32'h0)
		else $error("unmapped read returned nonzero data");
	rx_stamp_a: assert property (rx_sop |=> rx_stamp_valid)
		else $error("receive start got no stamp");
	tx_result_a: assert property (tx_sop && tx_stamp_operation inside
		{OP_ONE_STEP, OP_TWO_STEP} |-> ##[2:MAXW] tx_stamp_valid)
		else $error("stamped frame got no result");
	onestep_cause_a: assert property (tx_onestep_valid |-> $past(tx_sop)
		&& $past(tx_stamp_operation) == OP_ONE_STEP)
		else $error("one-step stamp without a one-step frame");
	tag_hold_a: assert property (!tx_stamp_valid |-> $stable(tx_stamp_tag))
		else $error("returned tag changed without a result");
	write_fault_a: assert property ($fell(tx_tag_write_fault)
		|-> $past(tx_clr) || $past(tx_clr, 2))
		else $error("write fault cleared without path reset");
	read_fault_a: assert property ($fell(tx_tag_read_fault)
		|-> $past(tx_clr) || $past(tx_clr, 2))
		else $error("read fault cleared without path reset");
endmodule
bind ptp_frame_timestamping ptp_stamp_checker chk (
	.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest, .tx_sop, .tx_stamp_operation, .tx_stamp_valid, .tx_stamp_tag,
	.tx_onestep_valid, .tx_tag_write_fault, .tx_tag_read_fault, .rx_sop, .rx_stamp_valid
);

// ---- testbench/ptp_client_model.sv ----
// client-side frame source and timer feed for the timestamping block
`timescale 1ns/10ps
module ptp_client_model
	import ptp_stamp_pkg::*;
(
	input  wire logic    clk_sys,
	output logic         tx_sop,
	output logic [1:0]   tx_stamp_operation,
	output logic [15:0]  tx_tag,
	output logic         rx_sop,
	output logic [79:0]  tx_timer,
	output logic [79:0]  rx_timer
);
	initial begin
		tx_sop = 1'b0;
		tx_stamp_operation = 2'h0;
		tx_tag = 16'h0;
		rx_sop = 1'b0;
		tx_timer = 80'h0;
		rx_timer = 80'h0;
	end
	// called at a rising edge; op and tag stand only in the first cycle
	task send_tx(input logic [1:0] op, input logic [15:0] tag, input logic last);
		tx_sop <= 1'b1;
		tx_stamp_operation <= op;
		tx_tag <= tag;
		@(posedge clk_sys);
		if (last) begin
			tx_sop <= 1'b0;
			tx_stamp_operation <= ~op; // stale code must not be reused
			tx_tag <= ~tag;
		end
	endtask
	// one receive start pulse
	task send_rx();
		rx_sop <= 1'b1;
		@(posedge clk_sys);
		rx_sop <= 1'b0;
	endtask
	// timers stand still; correction comes already adjusted by the caller
	task set_time(input logic [79:0] t, input logic [79:0] r);
		tx_timer <= t;
		rx_timer <= r;
	endtask
endmodule

// ---- testbench/ptp_frame_timestamping_tb.sv ----
// self-checking bench for the frame timestamping block
`timescale 1ns/10ps
module ptp_frame_timestamping_tb
	import ptp_stamp_pkg::*;
;
	localparam logic [79:0] T = {48'h0000_0000_0007, 32'h0000_0064};
	localparam logic [79:0] R = {48'h0000_0000_0002, 32'h3B9A_C9FE};
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] tx_gearbox_latency = 32'h0005_0000;
	logic [31:0] rx_gearbox_latency = 32'h0003_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, tx_sop, rx_sop, tx_stamp_valid, tx_onestep_valid;
	logic        rx_stamp_valid, tx_tag_write_fault, tx_tag_read_fault;
	logic [1:0]  tx_stamp_operation;
	logic [15:0] tx_tag, tx_stamp_tag;
	logic [79:0] tx_timer, rx_timer, tx_stamp, tx_onestep_stamp, rx_stamp;
	int          mismatches = 0;
	int          total_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	ptp_frame_timestamping #(.DEPTH(4)) DUT (
		.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .tx_timer, .tx_sop, .tx_stamp_operation,
		.tx_tag, .tx_gearbox_latency, .tx_stamp_valid, .tx_stamp_tag, .tx_stamp,
		.tx_onestep_valid, .tx_onestep_stamp, .tx_tag_write_fault, .tx_tag_read_fault,
		.rx_timer, .rx_sop, .rx_gearbox_latency, .rx_stamp_valid, .rx_stamp);
	ptp_client_model src (
		.clk_sys, .tx_sop, .tx_stamp_operation, .tx_tag, .rx_sop, .tx_timer, .rx_timer);
	task check(input logic [79:0] seen, input logic [79:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim();
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one bus cycle, held until waitrequest is seen low at a rising edge
	task bus(input logic rd, input logic [4:0] a, input logic [31:0] wd,
		output logic [31:0] d);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) mismatches++;
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task wr(input logic [4:0] a, input logic [31:0] wd);
		logic [31:0] d;
		bus(1'b0, a, wd, d);
	endtask
	task rdc(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b1, a, 32'h0, d);
		check(d, exp);
	endtask
	// next transmit result, looked at mid-cycle so edge updates have landed
	task wait_tx();
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (tx_stamp_valid !== 1'b1 && n < 20);
		if (n >= 20) mismatches++;
	endtask
	task regs();
		rdc(ADDR_CTRL, {26'h0, CTRL_RESET});
		rdc(ADDR_STATUS, 32'h0);
		check(tx_tag_write_fault, 1'b0);
		check(tx_tag_read_fault, 1'b0);
		wr(5'h14, 32'hFFFF_FFFF);
		rdc(5'h14, 32'h0);
		wr(ADDR_RX_LATENCY, 32'h0002_0000);
		rdc(ADDR_RX_LATENCY, 32'h0002_0000);
	endtask
	// back-to-back starts with ignored codes between stamped ones
	task tx_order();
		@(posedge clk_sys);
		fork
			begin
				src.send_tx(OP_TWO_STEP, 16'hA001, 1'b0);
				src.send_tx(OP_NONE, 16'hB002, 1'b0);
				src.send_tx(OP_RESERVED, 16'hC003, 1'b0);
				src.send_tx(OP_ONE_STEP, 16'hD004, 1'b0);
				src.send_tx(OP_TWO_STEP, 16'hE005, 1'b1);
			end
			begin
				wait_tx();
				check(tx_stamp_tag, 16'hA001);
				check(tx_stamp, T + 80'h5);
				wait_tx();
				check(tx_stamp_tag, 16'hD004);
				wait_tx();
				check(tx_stamp_tag, 16'hE005);
			end
		join
	endtask
	task tx_onestep();
		wr(ADDR_CTRL, 32'h0000_003E);
		wr(ADDR_ADJUST, 32'h0000_0010);
		wr(ADDR_TX_LATENCY, 32'h0004_0000);
		@(posedge clk_sys);
		src.send_tx(OP_ONE_STEP, 16'h1234, 1'b1);
		@(negedge clk_sys);
		check(tx_onestep_valid, 1'b1);
		check(tx_onestep_stamp, T + 80'hB);
		wait_tx();
		check(tx_stamp, T + 80'h9);
		check(tx_stamp_tag, 16'h1234);
	endtask
	// sign bit set on the correction must not survive
	task transparent();
		wr(ADDR_CTRL, 32'h0000_0039);
		@(posedge clk_sys);
		src.set_time({16'h0001, 64'h8000_0000_0064_8000}, R);
		@(posedge clk_sys);
		src.send_tx(OP_TWO_STEP, 16'h0C0C, 1'b1);
		wait_tx();
		check(tx_stamp, {16'h0001, 64'h0000_0000_0069_8000});
	endtask
	// both receive stamps cross the one-second boundary
	task rx_path();
		wr(ADDR_CTRL, 32'h0000_0038);
		@(posedge clk_sys);
		src.send_rx();
		@(negedge clk_sys);
		check(rx_stamp_valid, 1'b1);
		check(rx_stamp, {48'h0000_0000_0003, 32'h0000_0003});
		wr(ADDR_CTRL, 32'h0000_0008);
		@(posedge clk_sys);
		src.send_rx();
		@(negedge clk_sys);
		check(rx_stamp, {48'h0000_0000_0003, 32'h0000_0000});
	endtask
	// path reset write also loads control bits 0x38; a disabled one-step frame raises no one-step strobe but still returns its tag
	task tx_flush();
		wr(ADDR_CTRL, 32'h0000_0138);
		rdc(ADDR_CTRL, {26'h0, CTRL_RESET});
		rdc(ADDR_STATUS, 32'h0);
		@(posedge clk_sys);
		src.send_tx(OP_ONE_STEP, 16'h5A5A, 1'b1);
		@(negedge clk_sys);
		check(tx_onestep_valid, 1'b0);
		wait_tx();
		check(tx_stamp_tag, 16'h5A5A);
		check(tx_tag_write_fault, 1'b0);
		check(tx_tag_read_fault, 1'b0);
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		src.set_time(T, R);
		regs();
		tx_order();
		tx_onestep();
		transparent();
		rx_path();
		tx_flush();
		end_sim();
	end
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk_sys);
		mismatches++;
		end_sim();
	end
endmodule
